// ---- src/supply_supervisor_mode_control.sv ----
module supply_supervisor_mode_control #(
    parameter int CORE_RAMP_CYCLES =
        supply_supervisor_pkg::CORE_RAMP_CYCLES_DEFAULT,
    parameter int SLOW_CYCLES = supply_supervisor_pkg::SLOW_SETTLE_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire supply_supervisor_pkg::side_ctl_s coreSideCtl,
    input wire supply_supervisor_pkg::side_ctl_s highSideCtl,
    input wire logic coreCtlWrite,
    input wire logic highCtlWrite,
    input wire logic coreLevelRaise,
    input wire supply_supervisor_pkg::power_mode_e powerMode,
    input wire logic wakeInterrupt,
    input wire logic softPowerUpClear,
    output supply_supervisor_pkg::sup_state_e coreSupervisorState,
    output supply_supervisor_pkg::sup_state_e coreMonitorState,
    output supply_supervisor_pkg::sup_state_e highSupervisorState,
    output supply_supervisor_pkg::sup_state_e highMonitorState,
    output logic coreSideDelayFlag,
    output logic highSideDelayFlag,
    output logic fastWake,
    output logic hazardConfig,
    output logic wakeHung,
    output logic wakeUp,
    output logic resetRequest
);
    import supply_supervisor_pkg::*;

    // ----------------------------------------
    // State decoding
    // ----------------------------------------
    function automatic sup_state_e activeState(input logic en,
                                               input logic fast);
        if (!en) begin
            return SUP_OFF;
        end
        return fast ? SUP_FULL : SUP_NORMAL;
    endfunction

    function automatic sup_state_e deepState(input sup_state_e act,
                                             input logic retain,
                                             input logic autoCtl);
        if (autoCtl) begin
            return (retain && act == SUP_FULL) ? SUP_NORMAL : SUP_OFF;
        end
        return retain ? act : SUP_OFF;
    endfunction

    function automatic sup_state_e pickState(input sup_state_e act,
                                             input sup_state_e deep,
                                             input logic inDeep);
        return inDeep ? deep : act;
    endfunction

    // Monitors have no retain bit, so they always retain
    wire logic inDeep = (powerMode == MODE_DEEP);
    wire sup_state_e coreSupAct = activeState(
        coreSideCtl.supervisorEnable, coreSideCtl.supervisorFastSelect);
    wire sup_state_e coreMonAct = activeState(
        coreSideCtl.monitorEnable, coreSideCtl.monitorFastSelect);
    wire sup_state_e highSupAct = activeState(
        highSideCtl.supervisorEnable, highSideCtl.supervisorFastSelect);
    wire sup_state_e highMonAct = activeState(
        highSideCtl.monitorEnable, highSideCtl.monitorFastSelect);
    wire sup_state_e coreSupDeep = deepState(coreSupAct,
        coreSideCtl.supervisorRetain, coreSideCtl.autoControl);
    wire sup_state_e coreMonDeep = deepState(coreMonAct, 1'b1,
        coreSideCtl.autoControl);
    wire sup_state_e highSupDeep = deepState(highSupAct,
        highSideCtl.supervisorRetain, highSideCtl.autoControl);
    wire sup_state_e highMonDeep = deepState(highMonAct, 1'b1,
        highSideCtl.autoControl);

    // Fast wake when either core unit is off or in full mode
    wire logic coreFastCfg = (coreSupAct != SUP_NORMAL) ||
        (coreMonAct != SUP_NORMAL);
    wire logic highDropsOff =
        (highSupAct == SUP_NORMAL && highSupDeep == SUP_OFF) ||
        (highMonAct == SUP_NORMAL && highMonDeep == SUP_OFF);
    wire logic hazardNow = coreFastCfg && highDropsOff;

    // ----------------------------------------
    // Settling delays
    // ----------------------------------------
    logic [COUNT_WIDTH-1:0] coreDelay_reg;
    logic [COUNT_WIDTH-1:0] coreDelay_next;
    logic [COUNT_WIDTH-1:0] highDelay_reg;
    logic [COUNT_WIDTH-1:0] highDelay_next;
    wire logic [COUNT_WIDTH-1:0] coreLoad = coreSideCtl.supervisorFastSelect
        ? COUNT_WIDTH'(FAST_SETTLE_CYCLES)
        : COUNT_WIDTH'(SLOW_CYCLES);
    wire logic [COUNT_WIDTH-1:0] highLoad = highSideCtl.supervisorFastSelect
        ? COUNT_WIDTH'(FAST_SETTLE_CYCLES)
        : COUNT_WIDTH'(SLOW_CYCLES);
    wire logic coreDelayBusy = (coreDelay_reg != '0);
    wire logic highDelayBusy = (highDelay_reg != '0);

    // A core level raise restarts the core delay as well
    assign coreDelay_next = (coreCtlWrite || coreLevelRaise) ? coreLoad
        : coreDelayBusy ? coreDelay_reg - COUNT_WIDTH'(1) : coreDelay_reg;
    assign highDelay_next = highCtlWrite ? highLoad
        : highDelayBusy ? highDelay_reg - COUNT_WIDTH'(1) : highDelay_reg;

    // ----------------------------------------
    // Core level ramp
    // ----------------------------------------
    // Ramp length models how long the core rail takes to settle
    logic [COUNT_WIDTH-1:0] ramp_reg;
    logic [COUNT_WIDTH-1:0] ramp_next;
    wire logic rampBusy = (ramp_reg != '0);
    assign ramp_next = coreLevelRaise ? COUNT_WIDTH'(CORE_RAMP_CYCLES)
        : rampBusy ? ramp_reg - COUNT_WIDTH'(1) : ramp_reg;
    // Delay ending while the rail still ramps trips the supervisor
    wire logic rampTrip = rampBusy && coreDelay_reg == COUNT_WIDTH'(1) &&
        coreSupAct != SUP_OFF && !coreCtlWrite && !coreLevelRaise;

    // ----------------------------------------
    // Deep entry and wake
    // ----------------------------------------
    logic inDeep_reg;
    logic hung_reg;
    logic hung_next;
    logic hazardArmed_reg;
    logic hazardArmed_next;
    logic [COUNT_WIDTH-1:0] window_reg;
    logic [COUNT_WIDTH-1:0] window_next;
    wire logic deepEntry = inDeep && !inDeep_reg;
    wire logic flagsBusy = coreDelayBusy || highDelayBusy;
    wire logic windowOpen = (window_reg != '0);

    // Armed at entry; a flag still set counts on its own
    assign hazardArmed_next = deepEntry
        ? (hazardNow || flagsBusy)
        : (inDeep ? hazardArmed_reg : 1'b0);
    assign window_next = deepEntry ? COUNT_WIDTH'(HAZARD_WINDOW_CYCLES)
        : windowOpen ? window_reg - COUNT_WIDTH'(1) : window_reg;
    wire logic hangEvent = inDeep_reg && hazardArmed_reg && windowOpen &&
        wakeInterrupt;
    // Only rst or softPowerUpClear clears the hang; leaving deep mode does not
    assign hung_next = softPowerUpClear ? 1'b0
        : (hung_reg || hangEvent);

    always_ff @(posedge clock) begin
        if (rst || softPowerUpClear) begin
            coreDelay_reg <= '0;
            highDelay_reg <= '0;
            ramp_reg <= '0;
            inDeep_reg <= 1'b0;
            hung_reg <= 1'b0;
            hazardArmed_reg <= 1'b0;
            window_reg <= '0;
        end else begin
            coreDelay_reg <= coreDelay_next;
            highDelay_reg <= highDelay_next;
            ramp_reg <= ramp_next;
            inDeep_reg <= inDeep;
            hung_reg <= hung_next;
            hazardArmed_reg <= hazardArmed_next;
            window_reg <= window_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Registered so status never glitches; it lags the settings by one edge
    wire sup_state_e coreSupState_next =
        pickState(coreSupAct, coreSupDeep, inDeep);
    wire sup_state_e coreMonState_next =
        pickState(coreMonAct, coreMonDeep, inDeep);
    wire sup_state_e highSupState_next =
        pickState(highSupAct, highSupDeep, inDeep);
    wire sup_state_e highMonState_next =
        pickState(highMonAct, highMonDeep, inDeep);
    sup_state_e coreSupState_reg;
    sup_state_e coreMonState_reg;
    sup_state_e highSupState_reg;
    sup_state_e highMonState_reg;
    logic fastWake_reg;
    logic hazardConfig_reg;

    always_ff @(posedge clock) begin
        if (rst || softPowerUpClear) begin
            coreSupState_reg <= SUP_OFF;
            coreMonState_reg <= SUP_OFF;
            highSupState_reg <= SUP_OFF;
            highMonState_reg <= SUP_OFF;
            fastWake_reg <= 1'b0;
            hazardConfig_reg <= 1'b0;
        end else begin
            coreSupState_reg <= coreSupState_next;
            coreMonState_reg <= coreMonState_next;
            highSupState_reg <= highSupState_next;
            highMonState_reg <= highMonState_next;
            fastWake_reg <= coreFastCfg;
            hazardConfig_reg <= hazardNow;
        end
    end

    assign coreSupervisorState = coreSupState_reg;
    assign coreMonitorState = coreMonState_reg;
    assign highSupervisorState = highSupState_reg;
    assign highMonitorState = highMonState_reg;
    assign coreSideDelayFlag = coreDelayBusy;
    assign highSideDelayFlag = highDelayBusy;
    assign fastWake = fastWake_reg;
    assign hazardConfig = hazardConfig_reg;
    assign wakeHung = hung_reg;
    assign wakeUp = inDeep_reg && wakeInterrupt && !hung_reg && !hangEvent;
    assign resetRequest = rampTrip;

endmodule

// ---- src/supply_supervisor_pkg.sv ----
package supply_supervisor_pkg;

    // ----------------------------------------
    // Supervisor states and power modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        SUP_OFF,
        SUP_NORMAL,
        SUP_FULL
    } sup_state_e;

    typedef enum logic [1:0] {
        MODE_ACTIVE,
        MODE_LIGHT,
        MODE_DEEP
    } power_mode_e;

    // ----------------------------------------
    // Settings of one side
    // ----------------------------------------
    typedef struct packed {
        logic supervisorEnable;
        logic supervisorFastSelect;
        logic supervisorRetain;
        logic monitorEnable;
        logic monitorFastSelect;
        logic autoControl;
    } side_ctl_s;

    localparam side_ctl_s SIDE_CTL_RESET = '0;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLOCK_MHZ = 100;
    localparam int FAST_SETTLE_NS = 2000;
    localparam int SLOW_SETTLE_NS = 150000;
    localparam int HAZARD_WINDOW_NS = 1000;
    localparam int FAST_SETTLE_CYCLES = FAST_SETTLE_NS * CLOCK_MHZ / 1000;
    localparam int SLOW_SETTLE_CYCLES = SLOW_SETTLE_NS * CLOCK_MHZ / 1000;
    localparam int HAZARD_WINDOW_CYCLES =
        HAZARD_WINDOW_NS * CLOCK_MHZ / 1000;
    localparam int CORE_RAMP_CYCLES_DEFAULT = 5000;
    localparam int COUNT_WIDTH = 15;

endpackage

// ---- verification/supply_supervisor_mode_control_properties.sv ----
module supply_supervisor_mode_control_properties #(
    parameter int CORE_RAMP_CYCLES =
        supply_supervisor_pkg::CORE_RAMP_CYCLES_DEFAULT,
    parameter int SLOW_CYCLES = supply_supervisor_pkg::SLOW_SETTLE_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic softPowerUpClear,
    input wire logic coreCtlWrite,
    input wire logic coreLevelRaise,
    input wire logic wakeInterrupt,
    input wire supply_supervisor_pkg::side_ctl_s coreSideCtl,
    input wire supply_supervisor_pkg::side_ctl_s highSideCtl,
    input wire supply_supervisor_pkg::power_mode_e powerMode,
    input wire supply_supervisor_pkg::sup_state_e highSupervisorState,
    input wire logic coreSideDelayFlag,
    input wire logic fastWake,
    input wire logic hazardConfig,
    input wire logic wakeHung,
    input wire logic wakeUp,
    input wire logic resetRequest
);
    import supply_supervisor_pkg::*;
    // ----------------------------------------
    // Checks on the high side, wake logic, core delay flag and ramp reset
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (rst || softPowerUpClear);
    wire inDeep = powerMode == MODE_DEEP;
    wire sup_state_e highAct = !highSideCtl.supervisorEnable ? SUP_OFF :
        highSideCtl.supervisorFastSelect ? SUP_FULL : SUP_NORMAL;
    wire sup_state_e highDeep = !highSideCtl.supervisorRetain ? SUP_OFF :
        !highSideCtl.autoControl ? highAct :
        highAct == SUP_FULL ? SUP_NORMAL : SUP_OFF;
    wire coreFastExp = !coreSideCtl.supervisorEnable ||
        coreSideCtl.supervisorFastSelect || !coreSideCtl.monitorEnable ||
        coreSideCtl.monitorFastSelect;
    // State and fast-wake outputs are registered, so they answer one edge later
    a_active_high_map: assert property (
        !inDeep |=> highSupervisorState == $past(highAct))
        else $error("active map");
    a_deep_high_map: assert property (
        inDeep |=> highSupervisorState == $past(highDeep))
        else $error("deep map");
    a_wake_restores: assert property (
        $fell(inDeep) |=> highSupervisorState == $past(highAct))
        else $error("wake");
    a_fast_wake_map: assert property (
        1'b1 |=> fastWake == $past(coreFastExp)) else $error("fast wake");
    a_hazard_hangs: assert property (
        $rose(inDeep) && hazardConfig && $stable(coreSideCtl) &&
        $stable(highSideCtl) ##1 wakeInterrupt && inDeep
        |=> wakeHung) else $error("no hang");
    a_hang_sticky: assert property (
        wakeHung |=> wakeHung) else $error("hang dropped");
    a_hung_no_wake: assert property (
        wakeHung |-> !wakeUp) else $error("woke while hung");
    a_write_sets_flag: assert property (
        coreCtlWrite |=> coreSideDelayFlag) else $error("flag missing");
    // Only meaningful when the ramp outlasts the short delay
    a_fast_raise_reset: assert property (
        coreLevelRaise && coreSideCtl.supervisorEnable &&
        coreSideCtl.supervisorFastSelect &&
        CORE_RAMP_CYCLES > FAST_SETTLE_CYCLES
        |-> ##200 resetRequest) else $error("missing reset");
    // Holds a slow raise until a write or another raise replaces it
    logic slowRaise_reg;
    always_ff @(posedge clock) begin
        if (rst || softPowerUpClear || coreCtlWrite) begin
            slowRaise_reg <= 1'b0;
        end else if (coreLevelRaise) begin
            slowRaise_reg <= !coreSideCtl.supervisorFastSelect;
        end
    end
    a_slow_raise_safe: assert property (
        slowRaise_reg && SLOW_CYCLES > CORE_RAMP_CYCLES |-> !resetRequest)
        else $error("spurious reset");
endmodule

bind supply_supervisor_mode_control supply_supervisor_mode_control_properties
    #(.CORE_RAMP_CYCLES(CORE_RAMP_CYCLES), .SLOW_CYCLES(SLOW_CYCLES))
    props (
        .clock(clock),
        .rst(rst),
        .softPowerUpClear(softPowerUpClear),
        .coreCtlWrite(coreCtlWrite),
        .coreLevelRaise(coreLevelRaise),
        .wakeInterrupt(wakeInterrupt),
        .coreSideCtl(coreSideCtl),
        .highSideCtl(highSideCtl),
        .powerMode(powerMode),
        .highSupervisorState(highSupervisorState),
        .coreSideDelayFlag(coreSideDelayFlag),
        .fastWake(fastWake),
        .hazardConfig(hazardConfig),
        .wakeHung(wakeHung),
        .wakeUp(wakeUp),
        .resetRequest(resetRequest)
    );

// ---- verification/tb_supply_supervisor_mode_control.sv ----
module tb_supply_supervisor_mode_control;
    timeunit 1ns;
    timeprecision 1ns;
    import supply_supervisor_pkg::*;
    // ----------------------------------------
    // Bench
    // ----------------------------------------
    localparam int SLOW = 400;
    logic clock = 0, rst = 1, coreCtlWrite = 0, highCtlWrite = 0;
    logic coreLevelRaise = 0, wakeInterrupt = 0, softPowerUpClear = 0;
    side_ctl_s coreSideCtl = '0, highSideCtl = '0;
    power_mode_e powerMode = MODE_ACTIVE;
    sup_state_e coreSupervisorState, coreMonitorState;
    sup_state_e highSupervisorState, highMonitorState;
    logic coreSideDelayFlag, highSideDelayFlag, fastWake, hazardConfig;
    logic wakeHung, wakeUp, resetRequest;
    int fails = 0, tests_run = 0, cycles = 0;
    // Ramp above the 200-cycle short delay so the fast raise must reset
    supply_supervisor_mode_control #(.CORE_RAMP_CYCLES(300),
        .SLOW_CYCLES(SLOW)) dut (
        .clock(clock),
        .rst(rst),
        .coreSideCtl(coreSideCtl),
        .highSideCtl(highSideCtl),
        .coreCtlWrite(coreCtlWrite),
        .highCtlWrite(highCtlWrite),
        .coreLevelRaise(coreLevelRaise),
        .powerMode(powerMode),
        .wakeInterrupt(wakeInterrupt),
        .softPowerUpClear(softPowerUpClear),
        .coreSupervisorState(coreSupervisorState),
        .coreMonitorState(coreMonitorState),
        .highSupervisorState(highSupervisorState),
        .highMonitorState(highMonitorState),
        .coreSideDelayFlag(coreSideDelayFlag),
        .highSideDelayFlag(highSideDelayFlag),
        .fastWake(fastWake),
        .hazardConfig(hazardConfig),
        .wakeHung(wakeHung),
        .wakeUp(wakeUp),
        .resetRequest(resetRequest)
    );
    initial forever #5 clock = ~clock;
    task bad(string m);
        fails++;
        $display("BAD %0t %s", $time, m);
    endtask
    task conclude();
        if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clock) if (++cycles == 20000) begin
        fails++;
        conclude();
    end
    function automatic sup_state_e act(logic e, logic f);
        return e ? (f ? SUP_FULL : SUP_NORMAL) : SUP_OFF;
    endfunction
    task t_states();
        for (int i = 0; i < 128; i++) begin
            side_ctl_s c;
            sup_state_e s, m;
            logic fw, hz;
            c = i[6:1];
            s = act(c.supervisorEnable, c.supervisorFastSelect);
            m = act(c.monitorEnable, c.monitorFastSelect);
            fw = s != SUP_NORMAL || m != SUP_NORMAL;
            hz = fw && (s == SUP_NORMAL && (!c.supervisorRetain ||
                c.autoControl) || m == SUP_NORMAL && c.autoControl);
            if (i[0]) begin
                s = !c.supervisorRetain ? SUP_OFF : !c.autoControl ? s :
                    s == SUP_FULL ? SUP_NORMAL : SUP_OFF;
                if (c.autoControl) m = m == SUP_FULL ? SUP_NORMAL : SUP_OFF;
            end
            coreSideCtl = c;
            highSideCtl = c;
            powerMode = i[0] ? MODE_DEEP : MODE_ACTIVE;
            @(negedge clock);
            tests_run += 2;
            if (coreSupervisorState !== s || highSupervisorState !== s ||
                coreMonitorState !== m || highMonitorState !== m)
                bad("state");
            if (fastWake !== fw || hazardConfig !== hz) bad("wake cfg");
        end
        powerMode = MODE_ACTIVE;
    endtask
    task t_delay(logic hi, logic fs, int n);
        int k;
        coreSideCtl = {1'b1, fs, 4'h0};
        highSideCtl = coreSideCtl;
        if (hi) highCtlWrite = 1;
        else coreCtlWrite = 1;
        @(negedge clock);
        {coreCtlWrite, highCtlWrite} = 2'h0;
        k = 0;
        while ((hi ? highSideDelayFlag : coreSideDelayFlag) === 1'b1
            && k < 999) begin
            k++;
            @(negedge clock);
        end
        tests_run++;
        if (k != n) bad("delay length");
    endtask
    task t_raise(logic fs, int n);
        int k;
        coreSideCtl = {1'b1, fs, 4'h0};
        coreLevelRaise = 1;
        @(negedge clock);
        coreLevelRaise = 0;
        k = 0;
        while (resetRequest !== 1'b1 && k < 600) begin
            k++;
            @(negedge clock);
        end
        tests_run++;
        if (k != n) bad("reset timing");
        @(negedge clock);
    endtask
    task t_hang(side_ctl_s cc, side_ctl_s hc, logic wr, hz, viaRst);
        coreSideCtl = cc;
        highSideCtl = hc;
        repeat (999) if (coreSideDelayFlag || highSideDelayFlag)
            @(negedge clock);
        coreCtlWrite = wr;
        @(negedge clock);
        coreCtlWrite = 0;
        powerMode = MODE_DEEP;
        @(negedge clock);
        wakeInterrupt = 1;
        @(negedge clock);
        tests_run++;
        if (hazardConfig !== hz || wakeHung !== (hz || wr) ||
            wakeUp !== !(hz || wr)) bad("wake");
        wakeInterrupt = 0;
        powerMode = MODE_ACTIVE;
        if (viaRst) rst = 1;
        else softPowerUpClear = 1;
        @(negedge clock);
        {rst, softPowerUpClear} = 2'h0;
        tests_run++;
        if (wakeHung !== 1'b0) bad("hang not cleared");
    endtask
    initial begin
        repeat (2) @(negedge clock);
        rst = 0;
        t_states();
        t_delay(0, 1, FAST_SETTLE_CYCLES);
        t_delay(0, 0, SLOW);
        t_delay(1, 1, FAST_SETTLE_CYCLES);
        t_delay(1, 0, SLOW);
        t_raise(1, FAST_SETTLE_CYCLES - 1);
        t_raise(0, 600);
        t_hang(6'h00, 6'h20, 0, 1, 0);
        t_hang(6'h24, 6'h00, 1, 0, 1);
        t_hang(6'h24, 6'h00, 0, 0, 0);
        conclude();
    end
endmodule
